// ==== test/cbd_core_bench.sv ====
// Purpose: self-checking bench of the bus cycle and addressing decoder
// Assumes: program starts at 0100 through the reset vector
// Notes: bus activity is compared cycle by cycle at the falling edge
`timescale 1ns/1ps
`default_nettype none
module cbd_core_bench;
   import cbd_pkg::*;
   logic sys_clk;
   logic reset_n;
   logic [7:0] bus_rdata;
   logic [15:0] bus_addr;
   logic [7:0] bus_wdata;
   logic bus_write;
   cbd_cycle_t bus_cycle;
   logic [7:0] condition_code_register;
   int failures;
   int total_checks;
   cbd_core cbd_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_cycle(bus_cycle),
      .condition_code_register(condition_code_register));
   cbd_mem_model cbd_mem_model_i (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_rdata(bus_rdata));
   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // -----------------------------------------
   // shared helpers
   // -----------------------------------------
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask : check
   // wd[8] set means a write with data wd[7:0]
   task automatic step(input cbd_cycle_t cy, input logic [15:0] a, input logic [8:0] wd);
      @(negedge sys_clk);
      check(bus_cycle === cy && bus_addr === a, $sformatf("cycle %0d at %h", cy, a));
      check(bus_write === wd[8] && (!wd[8] || bus_wdata === wd[7:0]), "write strobe or data");
   endtask : step
   task automatic fetches(input logic [15:0] a, input int n);
      for (int i = 0; i < n; i++) step(CY_FETCH, a + 16'(i), 9'h000);
   endtask : fetches
   // unused memory holds one-cycle no-ops so the core keeps fetching in order
   task automatic restart(input logic [7:0] prog [$]);
      @(posedge sys_clk);
      #1 reset_n = 1'b0;
      for (int i = 0; i < 65536; i++) cbd_mem_model_i.mem[i] = 8'h9D;
      cbd_mem_model_i.mem[16'hFFFE] = 8'h01;
      cbd_mem_model_i.mem[16'hFFFF] = 8'h00;
      foreach (prog[i]) cbd_mem_model_i.mem[16'h0100 + i] = prog[i];
      repeat (5) @(posedge sys_clk);
      check(condition_code_register === CC_RESET && bus_cycle === CY_VECTOR, "reset state");
      #1 reset_n = 1'b1;
      step(CY_VECTOR, VEC_HI_ADDR, 9'h000);
      step(CY_VECTOR, VEC_LO_ADDR, 9'h000);
   endtask : restart
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_load_store();
      restart({8'hA6, 8'h55, 8'hC7, 8'h02, 8'h00, 8'h99, 8'hBB, 8'h40, 8'hE6, 8'h10});
      fetches(16'h0100, 5);
      step(CY_WRITE, 16'h0200, 9'h155);
      fetches(16'h0105, 2);
      check(condition_code_register === 8'h69, "carry after set");
      fetches(16'h0107, 1);
      step(CY_READ, 16'h0040, 9'h000);
      fetches(16'h0108, 1);
      // 55 + 9D gives F2 with half carry and negative, no carry
      check(condition_code_register === 8'h7C, "condition codes after add");
      fetches(16'h0109, 1);
      step(CY_READ, 16'h0010, 9'h000);
      fetches(16'h010A, 1);
   endtask : t_load_store
   task automatic t_stack();
      restart({8'hA6, 8'hA5, 8'h87, 8'h86});
      fetches(16'h0100, 3);
      step(CY_PUSH, 16'h00FF, 9'h1A5);
      fetches(16'h0103, 1);
      step(CY_FREE, 16'h0104, 9'h000);
      step(CY_POP, 16'h00FF, 9'h000);
      fetches(16'h0104, 1);
   endtask : t_stack
   // farthest reach forward, then farthest reach backward
   task automatic t_branch();
      restart({8'h20, 8'h7F});
      cbd_mem_model_i.mem[16'h0181] = 8'h20;
      cbd_mem_model_i.mem[16'h0182] = 8'h80;
      fetches(16'h0100, 2);
      fetches(16'h0181, 2);
      fetches(16'h0103, 1);
   endtask : t_branch
   task automatic t_index();
      restart({8'hAE, 8'h40, 8'hF6, 8'h71, 8'h00, 8'h61, 8'h10, 8'h00, 8'hD6, 8'h12, 8'h34,
               8'hA6, 8'h00, 8'h71, 8'h05});
      fetches(16'h0100, 3);
      step(CY_READ, 16'h0040, 9'h000);
      fetches(16'h0103, 1);
      step(CY_READ, 16'h0040, 9'h000);
      fetches(16'h0104, 3);
      step(CY_READ, 16'h0051, 9'h000);
      fetches(16'h0107, 4);
      step(CY_READ, 16'h1276, 9'h000);
      fetches(16'h010B, 3);
      // accumulator 00 against 9D: compare fails, no branch to 0114
      step(CY_READ, 16'h0042, 9'h000);
      fetches(16'h010E, 2);
   endtask : t_index
   task automatic t_stack_mode();
      restart({8'h9E, 8'hE6, 8'h10, 8'h9E, 8'hD6, 8'h12, 8'h34});
      fetches(16'h0100, 3);
      step(CY_READ, 16'h010F, 9'h000);
      fetches(16'h0103, 4);
      step(CY_READ, 16'h1333, 9'h000);
      fetches(16'h0107, 1);
   endtask : t_stack_mode
   // 0 - 1 gives FF with borrow and negative set
   task automatic t_negate();
      restart({8'hA6, 8'h01, 8'h40, 8'hC7, 8'h02, 8'h00});
      fetches(16'h0100, 6);
      step(CY_WRITE, 16'h0200, 9'h1FF);
      fetches(16'h0106, 1);
      check(condition_code_register === 8'h6D, "condition codes after negate");
   endtask : t_negate
   // -----------------------------------------
   // verdict and main sequence
   // -----------------------------------------
   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      reset_n = 1'b0;
      failures = 0;
      total_checks = 0;
      t_load_store();
      t_stack();
      t_branch();
      t_index();
      t_stack_mode();
      t_negate();
      end_of_test();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #20000;
      failures++;
      end_of_test();
   end
endmodule : cbd_core_bench
`default_nettype wire

// ==== test/cbd_mem_model.sv ====
// Purpose: system bus memory answering the decoder's cycles
// Assumes: read data follows the address within the same cycle
// Notes: no wait states; a write lands on the rising edge
`timescale 1ns/1ps
`default_nettype none
module cbd_mem_model (
   // clock
   input wire logic sys_clk,
   // system bus
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_write,
   output logic [7:0] bus_rdata
);
   logic [7:0] mem [0:65535];
   // -----------------------------------------
   // read and write paths
   // -----------------------------------------
   // no stale byte on the data lines while the core writes
   always_comb begin
      bus_rdata = bus_write ? ~bus_wdata : mem[bus_addr];
   end
   // the core holds write cycles for exactly one clock
   always @(posedge sys_clk) begin
      if (bus_write === 1'b1) begin
         mem[bus_addr] <= bus_wdata;
      end
   end
endmodule : cbd_mem_model
`default_nettype wire

// ==== verilog/cbd_core.sv ====
// Purpose: bus cycle sequencer and addressing decoder of an 8-bit cpu
// Assumes: bus_rdata is valid in the cycle that shows the read
// Notes: one bus cycle per clock; unlisted opcodes of the inherent columns act as one-cycle no-ops
`timescale 1ns/1ps
`default_nettype none
module cbd_core (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // system bus
   input wire logic [7:0] bus_rdata,
   output logic [15:0] bus_addr,
   output logic [7:0] bus_wdata,
   output logic bus_write,
   output cbd_pkg::cbd_cycle_t bus_cycle,
   // status
   output logic [7:0] condition_code_register
);
   import cbd_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // returns {h, v, c, result}; subtract adds the inverted operand
   function automatic logic [10:0] arith(input logic [7:0] a, input logic [7:0] b,
                                         input logic sub, input logic cin);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] hs;
      logic ci;
      bb = sub ? ~b : b;
      ci = sub ? ~cin : cin;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, ci}; // see RULE13
      hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      return {hs[4], (a[7] == bb[7]) && (s[7] != a[7]), sub ^ s[8], s[7:0]};
   endfunction : arith

   // addressing mode from page and opcode
   function automatic cbd_mode_t decode(input logic pg2, input logic [7:0] op);
      if (pg2) begin // see RULE15
         if (op[7:4] == COL_IDX16) return stack_offset16_mode;
         if (op[7:4] == COL_IX1) return stack_offset8_mode;
         return M_INH;
      end
      if (op == OP_CBEQ_IXP) return indexed_post_increment_mode;
      if (op == OP_CBEQ_IX1P) return indexed_offset8_post_increment_mode;
      unique case (op[7:4])
         COL_REL: return M_REL;
         COL_IMM: return M_IMM;
         COL_DIR: return M_DIR;
         COL_EXT: return M_EXT;
         COL_IDX16: return indexed_offset16_mode;
         COL_IX1: return M_IX1;
         COL_IX: return M_IX;
         default: return M_INH;
      endcase
   endfunction : decode

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cbd_state_t st_r, st_nxt;
   cbd_mode_t mode_r, mode_nxt, mode;
   cbd_cycle_t cyc_r, cyc_nxt;
   logic [15:0] pc_r, pc_nxt, hx_r, hx_nxt, sp_r, sp_nxt, ea_r, ea_nxt, addr_r, addr_nxt, rel;
   logic [7:0] acc_r, acc_nxt, cc_r, cc_nxt, ir_r, ir_nxt, wd_r, wd_nxt, opc, res;
   logic take_r, take_nxt, wr_r, wr_nxt, go_mem, do_alu, br_cond, upd, store;
   logic [10:0] ar;

   // ------------------------------------------------------------
   // sequencer and datapath next values
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      pc_nxt = pc_r;
      acc_nxt = acc_r;
      hx_nxt = hx_r;
      sp_nxt = sp_r;
      cc_nxt = cc_r;
      ir_nxt = ir_r;
      mode_nxt = mode_r;
      ea_nxt = ea_r;
      take_nxt = take_r;
      opc = ir_r;
      mode = mode_r;
      go_mem = 1'b0;
      do_alu = 1'b0;
      upd = 1'b0;
      res = acc_r;
      ar = '0;
      // offset is relative to the byte after the offset itself
      rel = pc_r + 16'h0001 + 16'($signed(bus_rdata)); // see RULE11, see RULE14
      // branch condition from the low nibble of the branch opcode
      unique case (ir_r[3:0])
         BR_ALWAYS: br_cond = 1'b1;
         BR_CC: br_cond = !cc_r[CC_C];
         BR_CS: br_cond = cc_r[CC_C];
         BR_NE: br_cond = !cc_r[CC_Z];
         BR_EQ: br_cond = cc_r[CC_Z];
         BR_HCC: br_cond = !cc_r[CC_H];
         BR_HCS: br_cond = cc_r[CC_H];
         BR_PL: br_cond = !cc_r[CC_N];
         BR_MI: br_cond = cc_r[CC_N];
         default: br_cond = 1'b0;
      endcase
      unique case (st_r)
         S_VHI: begin
            pc_nxt = {bus_rdata, pc_r[7:0]}; // see RULE5
            st_nxt = S_VLO;
         end
         S_VLO: begin
            pc_nxt = {pc_r[15:8], bus_rdata};
            st_nxt = S_OP;
         end
         S_OP, S_OP2: begin
            pc_nxt = pc_r + 16'h0001; // see RULE2
            opc = bus_rdata;
            ir_nxt = bus_rdata;
            if (st_r == S_OP && bus_rdata == OP_PREFIX) begin
               st_nxt = S_OP2; // see RULE15
            end else begin
               mode = decode(st_r == S_OP2, bus_rdata);
               mode_nxt = mode;
               st_nxt = S_A1; // see RULE12
               if (mode == M_INH) begin
                  st_nxt = S_OP;
                  // second page inherent codes are not decoded and act as no-ops
                  if (st_r == S_OP) begin
                     unique case (bus_rdata)
                        OP_NEGA: begin
                           ar = arith(8'h00, acc_r, 1'b1, 1'b0); // see RULE13
                           acc_nxt = ar[7:0];
                           cc_nxt[CC_C] = ar[8];
                           cc_nxt[CC_V] = ar[9];
                           res = ar[7:0];
                           upd = 1'b1;
                        end
                        OP_PSHA: st_nxt = S_PSH;
                        OP_PULA: st_nxt = S_FREE; // a free cycle comes before the pop; stack pointer moves with the pop
                        OP_TAP: cc_nxt = acc_r | CC_ONES; // see RULE16
                        OP_TPA: acc_nxt = cc_r;
                        OP_TAX: hx_nxt = {hx_r[15:8], acc_r};
                        OP_TXA: acc_nxt = hx_r[7:0];
                        OP_CLC: cc_nxt[CC_C] = 1'b0;
                        OP_SEC: cc_nxt[CC_C] = 1'b1;
                        OP_CLI: cc_nxt[CC_I] = 1'b0;
                        OP_SEI: cc_nxt[CC_I] = 1'b1;
                        OP_RSP: sp_nxt = {sp_r[15:8], SP_RESET[7:0]};
                        default: ;
                     endcase
                  end
               end else if (mode == M_IX || mode == indexed_post_increment_mode) begin
                  ea_nxt = hx_r; // see RULE6
                  go_mem = 1'b1;
               end
            end
         end
         S_A1: begin
            pc_nxt = pc_r + 16'h0001;
            go_mem = 1'b1;
            unique case (mode_r)
               M_IMM: begin
                  go_mem = 1'b0;
                  do_alu = 1'b1;
                  st_nxt = S_OP;
               end
               M_REL: begin
                  go_mem = 1'b0;
                  st_nxt = S_OP;
                  if (br_cond) pc_nxt = rel; // see RULE11
               end
               M_DIR: ea_nxt = {8'h00, bus_rdata};
               M_IX1, indexed_offset8_post_increment_mode: ea_nxt = hx_r + {8'h00, bus_rdata}; // see RULE7
               stack_offset8_mode: ea_nxt = sp_r + {8'h00, bus_rdata}; // see RULE8
               default: begin
                  go_mem = 1'b0;
                  ea_nxt = {bus_rdata, 8'h00}; // high byte of a two-byte operand
                  st_nxt = S_A2;
               end
            endcase
         end
         S_A2: begin
            pc_nxt = pc_r + 16'h0001;
            go_mem = 1'b1;
            ea_nxt = {ea_r[15:8], bus_rdata};
            if (mode_r == indexed_offset16_mode) ea_nxt = hx_r + {ea_r[15:8], bus_rdata}; // see RULE10
            if (mode_r == stack_offset16_mode) ea_nxt = sp_r + {ea_r[15:8], bus_rdata}; // see RULE9
         end
         S_RD: begin
            st_nxt = S_OP;
            if (mode_r == indexed_post_increment_mode || mode_r == indexed_offset8_post_increment_mode) begin
               take_nxt = acc_r == bus_rdata;
               hx_nxt = hx_r + 16'h0001; // see RULE6, see RULE7
               st_nxt = S_REL;
            end else begin
               do_alu = 1'b1;
            end
         end
         S_REL: begin
            pc_nxt = take_r ? rel : pc_r + 16'h0001; // see RULE11
            st_nxt = S_OP;
         end
         S_WR: st_nxt = S_OP;
         S_PSH: begin
            sp_nxt = sp_r - 16'h0001; // see RULE3
            st_nxt = S_OP;
         end
         S_FREE: st_nxt = S_POP;
         S_POP: begin
            acc_nxt = bus_rdata;
            sp_nxt = sp_r + 16'h0001; // see RULE4
            st_nxt = S_OP;
         end
         default: st_nxt = S_VHI; // illegal code restarts from the vector
      endcase
      // operand cycle: the compare-and-branch modes never store
      store = opc[3:0] == ALU_STA && mode != indexed_post_increment_mode
              && mode != indexed_offset8_post_increment_mode;
      if (go_mem) begin
         st_nxt = store ? S_WR : S_RD;
         do_alu = store;
      end
      // register/memory operations on the accumulator and the index low byte
      if (do_alu) begin
         upd = 1'b1;
         unique case (opc[3:0])
            ALU_SUB, ALU_CMP, ALU_SBC, ALU_ADD, ALU_ADC: begin
               ar = arith(acc_r, bus_rdata, !opc[3], (opc[3:0] == ALU_SBC || opc[3:0] == ALU_ADC) & cc_r[CC_C]);
               res = ar[7:0];
               cc_nxt[CC_C] = ar[8];
               cc_nxt[CC_V] = ar[9];
               if (opc[3]) cc_nxt[CC_H] = ar[10];
               if (opc[3:0] != ALU_CMP) acc_nxt = res;
            end
            ALU_AND, ALU_BIT: res = acc_r & bus_rdata;
            ALU_EOR: res = acc_r ^ bus_rdata;
            ALU_ORA: res = acc_r | bus_rdata;
            ALU_LDA, ALU_LDX: res = bus_rdata;
            ALU_STA: res = acc_r;
            default: upd = 1'b0;
         endcase
         if (opc[3:0] inside {ALU_AND, ALU_EOR, ALU_ORA, ALU_LDA}) acc_nxt = res;
         if (opc[3:0] == ALU_LDX) hx_nxt = {hx_r[15:8], res};
         if (upd && (opc[2] || opc[3:0] == ALU_EOR || opc[3:0] == ALU_ORA)) cc_nxt[CC_V] = 1'b0;
      end
      if (upd) begin
         cc_nxt[CC_N] = res[7]; // see RULE16
         cc_nxt[CC_Z] = res == 8'h00;
      end
      // bus outputs of the next cycle
      addr_nxt = pc_nxt;
      wr_nxt = 1'b0;
      wd_nxt = wd_r;
      cyc_nxt = CY_FETCH;
      unique case (st_nxt)
         S_VHI: begin
            addr_nxt = VEC_HI_ADDR;
            cyc_nxt = CY_VECTOR;
         end
         S_VLO: begin
            addr_nxt = VEC_LO_ADDR;
            cyc_nxt = CY_VECTOR;
         end
         S_RD: begin
            addr_nxt = ea_nxt;
            cyc_nxt = CY_READ;
         end
         S_WR, S_PSH: begin
            addr_nxt = (st_nxt == S_PSH) ? sp_nxt : ea_nxt; // see RULE3
            wr_nxt = 1'b1;
            wd_nxt = acc_nxt;
            cyc_nxt = (st_nxt == S_PSH) ? CY_PUSH : CY_WRITE;
         end
         S_POP: begin
            addr_nxt = sp_nxt + 16'h0001; // see RULE4
            cyc_nxt = CY_POP;
         end
         S_FREE: cyc_nxt = CY_FREE; // see RULE1
         default: ;
      endcase
   end

   // registers only; reset starts with the high vector byte
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= S_VHI;
         mode_r <= M_INH;
         cyc_r <= CY_VECTOR;
         pc_r <= 16'h0000;
         hx_r <= 16'h0000;
         sp_r <= SP_RESET;
         ea_r <= 16'h0000;
         addr_r <= VEC_HI_ADDR;
         acc_r <= 8'h00;
         cc_r <= CC_RESET;
         ir_r <= 8'h00;
         wd_r <= 8'h00;
         take_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         mode_r <= mode_nxt;
         cyc_r <= cyc_nxt;
         pc_r <= pc_nxt;
         hx_r <= hx_nxt;
         sp_r <= sp_nxt;
         ea_r <= ea_nxt;
         addr_r <= addr_nxt;
         acc_r <= acc_nxt;
         cc_r <= cc_nxt;
         ir_r <= ir_nxt;
         wd_r <= wd_nxt;
         take_r <= take_nxt;
         wr_r <= wr_nxt;
      end
   end

   assign bus_addr = addr_r;
   assign bus_wdata = wd_r;
   assign bus_write = wr_r;
   assign bus_cycle = cyc_r;
   assign condition_code_register = cc_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_vec_hi;
      bus_cycle == CY_VECTOR && bus_addr == VEC_HI_ADDR;
   endsequence
   sequence s_vec_lo;
      bus_cycle == CY_VECTOR && bus_addr == VEC_LO_ADDR;
   endsequence
   sequence s_two_byte(cbd_mode_t m);
      st_r == S_A1 && mode_r == m ##1 st_r == S_A2;
   endsequence
   a_free_cycle: assert property (bus_cycle == CY_FREE |-> !bus_write ##1 bus_cycle != CY_FREE) // see RULE1
      else $error("free cycle not a single read");
   a_fetch_next: assert property ((st_r == S_OP || st_r == S_OP2) ##1 bus_cycle == CY_FETCH // see RULE2
      |-> bus_addr == $past(bus_addr) + 16'h0001) else $error("fetch not sequential");
   a_push_byte: assert property (bus_cycle == CY_PUSH |-> bus_write && bus_addr == sp_r && bus_wdata == acc_r // see RULE3
      ##1 sp_r == $past(sp_r) - 16'h0001 && !bus_write) else $error("push wrong");
   a_pop_byte: assert property (bus_cycle == CY_POP |-> !bus_write && bus_addr == sp_r + 16'h0001 // see RULE4
      ##1 sp_r == $past(sp_r) + 16'h0001 && acc_r == $past(bus_rdata)) else $error("pop wrong");
   a_vector_order: assert property (s_vec_hi |=> s_vec_lo ##1 // see RULE5
      (bus_cycle == CY_FETCH && bus_addr == {$past(bus_rdata, 2), $past(bus_rdata)})) else $error("vector order");
   a_post_incr: assert property (st_r == S_RD && (mode_r == indexed_post_increment_mode // see RULE6
      || mode_r == indexed_offset8_post_increment_mode) |=> hx_r == $past(hx_r) + 16'h0001) else $error("no post inc");
   a_index8_addr: assert property (st_r == S_A1 && mode_r == indexed_offset8_post_increment_mode // see RULE7
      |=> bus_cycle == CY_READ && bus_addr == $past(hx_r) + {8'h00, $past(bus_rdata)}) else $error("index offset8 address");
   a_stack8_addr: assert property (st_r == S_A1 && mode_r == stack_offset8_mode // see RULE8
      |=> bus_addr == $past(sp_r) + {8'h00, $past(bus_rdata)}) else $error("stack offset8 address");
   a_stack16_addr: assert property (s_two_byte(stack_offset16_mode) // see RULE9
      |=> bus_addr == $past(sp_r) + {$past(bus_rdata, 2), $past(bus_rdata)}) else $error("stack offset16 address");
   a_index16_addr: assert property (s_two_byte(indexed_offset16_mode) // see RULE10
      |=> bus_addr == $past(hx_r) + {$past(bus_rdata, 2), $past(bus_rdata)}) else $error("index offset16 address");
   a_branch_target: assert property (st_r == S_A1 && mode_r == M_REL && br_cond |=> bus_cycle == CY_FETCH // see RULE11, RULE14
      && bus_addr == $past(pc_r) + 16'h0001 + 16'($signed($past(bus_rdata)))) else $error("branch target");
   a_operand_len: assert property (st_r == S_A2 |-> $past(st_r) == S_A1 ##1 st_r != S_A2) // see RULE12
      else $error("operand too long");
   a_negate_twos: assert property (st_r == S_OP && bus_rdata == OP_NEGA // see RULE13
      |=> acc_r == 8'h00 - $past(acc_r)) else $error("negate wrong");
   a_prefix_page: assert property (st_r == S_OP && bus_rdata == OP_PREFIX // see RULE15
      |=> st_r == S_OP2 && bus_cycle == CY_FETCH) else $error("prefix not taken");
   a_cc_carry: assert property (st_r == S_OP && bus_rdata == OP_SEC |=> cc_r[CC_C] // see RULE16
      && (cc_r & CC_ONES) == CC_ONES) else $error("carry not set");
endmodule : cbd_core
`default_nettype wire

// ==== verilog/cbd_pkg.sv ====
// Purpose: constants and types of the 8-bit cpu bus cycle and addressing decoder
// Assumes: one clock, memory answers a read within the same bus cycle
// Notes: opcode and field values shared by the core and its checks
//
// Behaviour
// RULE1: free cycle needs no bus, lasts one clock, shows as read.
// RULE2: program fetch reads the next sequential program byte.
// RULE3: push writes one byte at the stack pointer address.
// RULE4: pop reads exactly one byte from the stack.
// RULE5: vector read from top page, high byte first, low byte next.
// RULE6: indexed no-offset mode increments index after use.
// RULE7: indexed 8-bit offset mode adds offset, then increments index.
// RULE8: stack mode adds 8-bit offset to stack pointer.
// RULE9: stack mode adds 16-bit offset to stack pointer.
// RULE10: indexed mode adds 16-bit stream offset to index pair.
// RULE11: branch adds one signed offset byte to program counter.
// RULE12: operands after the opcode are one or two bytes.
// RULE13: subtract and negate use two's complement.
// RULE14: branch reach is -128..+127 from the next instruction.
// RULE15: prefix byte selects the second opcode page.
// RULE16: condition codes hold V, H, I, N, Z and C.
`default_nettype none
package cbd_pkg;
   // ------------------------------------------------------------
   // sequencer states, one per bus cycle
   // ------------------------------------------------------------
   typedef enum logic [11:0] {
      S_VHI = 12'h001, S_VLO = 12'h002, S_OP = 12'h004, S_OP2 = 12'h008,
      S_A1 = 12'h010, S_A2 = 12'h020, S_RD = 12'h040, S_WR = 12'h080,
      S_PSH = 12'h100, S_POP = 12'h200, S_FREE = 12'h400, S_REL = 12'h800
   } cbd_state_t;
   typedef enum logic [2:0] {
      CY_FREE = 3'h0, CY_FETCH = 3'h1, CY_READ = 3'h2, CY_WRITE = 3'h3,
      CY_PUSH = 3'h4, CY_POP = 3'h5, CY_VECTOR = 3'h6
   } cbd_cycle_t;
   typedef enum logic [3:0] {
      M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, indexed_offset16_mode,
      stack_offset8_mode, stack_offset16_mode, indexed_post_increment_mode,
      indexed_offset8_post_increment_mode, M_REL
   } cbd_mode_t;
   // ------------------------------------------------------------
   // reset values, addresses, condition code bit positions
   // ------------------------------------------------------------
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [7:0] CC_RESET = 8'h68;
   localparam logic [7:0] CC_ONES = 8'h60;
   localparam int unsigned CC_V = 7;
   localparam int unsigned CC_H = 4;
   localparam int unsigned CC_I = 3;
   localparam int unsigned CC_N = 2;
   localparam int unsigned CC_Z = 1;
   localparam int unsigned CC_C = 0;
   // ------------------------------------------------------------
   // opcodes, columns and low-nibble operations
   // ------------------------------------------------------------
   localparam logic [7:0] OP_PREFIX = 8'h9E;
   localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
   localparam logic [7:0] OP_CBEQ_IX1P = 8'h61;
   localparam logic [7:0] OP_NEGA = 8'h40;
   localparam logic [7:0] OP_PSHA = 8'h87;
   localparam logic [7:0] OP_PULA = 8'h86;
   localparam logic [7:0] OP_TAP = 8'h84;
   localparam logic [7:0] OP_TPA = 8'h85;
   localparam logic [7:0] OP_TAX = 8'h97;
   localparam logic [7:0] OP_TXA = 8'h9F;
   localparam logic [7:0] OP_CLC = 8'h98;
   localparam logic [7:0] OP_SEC = 8'h99;
   localparam logic [7:0] OP_CLI = 8'h9A;
   localparam logic [7:0] OP_SEI = 8'h9B;
   localparam logic [7:0] OP_RSP = 8'h9C;
   localparam logic [3:0] COL_REL = 4'h2;
   localparam logic [3:0] COL_IMM = 4'hA;
   localparam logic [3:0] COL_DIR = 4'hB;
   localparam logic [3:0] COL_EXT = 4'hC;
   localparam logic [3:0] COL_IDX16 = 4'hD;
   localparam logic [3:0] COL_IX1 = 4'hE;
   localparam logic [3:0] COL_IX = 4'hF;
   localparam logic [3:0] ALU_SUB = 4'h0;
   localparam logic [3:0] ALU_CMP = 4'h1;
   localparam logic [3:0] ALU_SBC = 4'h2;
   localparam logic [3:0] ALU_AND = 4'h4;
   localparam logic [3:0] ALU_BIT = 4'h5;
   localparam logic [3:0] ALU_LDA = 4'h6;
   localparam logic [3:0] ALU_STA = 4'h7;
   localparam logic [3:0] ALU_EOR = 4'h8;
   localparam logic [3:0] ALU_ADC = 4'h9;
   localparam logic [3:0] ALU_ORA = 4'hA;
   localparam logic [3:0] ALU_ADD = 4'hB;
   localparam logic [3:0] ALU_LDX = 4'hE;
   localparam logic [3:0] BR_ALWAYS = 4'h0;
   localparam logic [3:0] BR_CC = 4'h4;
   localparam logic [3:0] BR_CS = 4'h5;
   localparam logic [3:0] BR_NE = 4'h6;
   localparam logic [3:0] BR_EQ = 4'h7;
   localparam logic [3:0] BR_HCC = 4'h8;
   localparam logic [3:0] BR_HCS = 4'h9;
   localparam logic [3:0] BR_PL = 4'hA;
   localparam logic [3:0] BR_MI = 4'hB;
endpackage : cbd_pkg
`default_nettype wire
